/* File: shared/pmt_pkg.sv */
package pmt_pkg;

	// register bus geometry
	localparam int AVS_ADDR_W = 5;
	localparam int AVS_DATA_W = 32;

	// byte offsets of the register words
	localparam logic [4:0] OFF_COUNT = 5'h00;
	localparam logic [4:0] OFF_PERIOD = 5'h04;
	localparam logic [4:0] OFF_CTRL = 5'h08;
	localparam logic [4:0] OFF_IRQ_REQ = 5'h0C;
	localparam logic [4:0] OFF_IRQ_EN = 5'h10;
	localparam logic [4:0] OFF_STATE = 5'h14;

	// control word fields
	localparam int CTRL_PRE_LSB = 0;
	localparam int CTRL_PRE_MSB = 1;
	localparam int CTRL_RUN_BIT = 2;
	localparam int CTRL_POST_LSB = 3;
	localparam int CTRL_POST_MSB = 6;
	localparam int CTRL_UNUSED_BIT = 7;

	// interrupt request and enable words share this layout
	localparam int IRQ_FLAG_BIT = 1;

	// state word fields
	localparam int STATE_POST_LSB = 0;
	localparam int STATE_POST_MSB = 3;
	localparam int STATE_MATCH_BIT = 4;
	localparam int STATE_RUN_BIT = 5;

	// values after reset
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// clocking: CLK is the oscillator, instruction clock is CLK / 4
	localparam int CLK_MHZ = 200;
	localparam int INST_DIV = 4;
	localparam logic [1:0] INST_LAST = 2'h3;

	// prescaler terminal counts (ratio minus one)
	localparam logic [3:0] PRE_LAST_1 = 4'h0;
	localparam logic [3:0] PRE_LAST_4 = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hF;

	typedef enum logic [1:0] {
		PRE_DIV1 = 2'b00,
		PRE_DIV4 = 2'b01,
		PRE_DIV16A = 2'b10,
		PRE_DIV16B = 2'b11
	} pmt_prescale_t;

endpackage : pmt_pkg

/* File: shared/pmt_tick_if.sv */
`timescale 1ns/1ps
interface pmt_tick_if;
	logic run;
	logic clear;
	logic [1:0] prescale_sel;
	logic pre_tick;

	modport ctl (
		output run,
		output clear,
		output prescale_sel,
		input pre_tick
	);

	modport div (
		input run,
		input clear,
		input prescale_sel,
		output pre_tick
	);
endinterface : pmt_tick_if

/* File: src/pmt_prescaler.sv */
`timescale 1ns/1ps
module pmt_prescaler
	import pmt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// timer side
	pmt_tick_if.div tick
);

	logic [1:0] inst_phase_reg;
	logic inst_tick;
	logic [3:0] pre_cnt_reg;
	logic [3:0] pre_last;
	logic pre_tick_reg;

	// instruction clock enable, oscillator divided by four
	always_ff @(posedge clk)
	begin
		if (srst)
			inst_phase_reg <= 2'h0;
		else
			inst_phase_reg <= inst_phase_reg + 2'h1;
	end

	assign inst_tick = (inst_phase_reg == INST_LAST);

	always_comb
	begin
		unique case (pmt_prescale_t'(tick.prescale_sel))
			PRE_DIV1: pre_last = PRE_LAST_1;
			PRE_DIV4: pre_last = PRE_LAST_4;
			PRE_DIV16A: pre_last = PRE_LAST_16;
			PRE_DIV16B: pre_last = PRE_LAST_16;
		endcase
	end

	// prescaler counts instruction ticks only while the timer runs
	always_ff @(posedge clk)
	begin
		if (srst || tick.clear)
			pre_cnt_reg <= 4'h0;
		else if (inst_tick && tick.run)
		begin
			if (pre_cnt_reg >= pre_last)
				pre_cnt_reg <= 4'h0;
			else
				pre_cnt_reg <= pre_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || tick.clear)
			pre_tick_reg <= 1'b0;
		else
			pre_tick_reg <= inst_tick && tick.run &&
				(pre_cnt_reg >= pre_last);
	end

	assign tick.pre_tick = pre_tick_reg;

endmodule : pmt_prescaler

/* File: src/pmt_timer.sv */
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
//
// Contract
// R1 - count clock is oscillator divided by four, then through the prescaler
// R2 - prescale select 00 gives 1, 01 gives 4, 1x gives 16
// R3 - every prescaler output pulse adds one to the count register
// R4 - count compared continuously with period, counts up from zero
// R5 - on match next increment loads zero and advances the postscaler
// R6 - postscaler output sets the timer interrupt flag
// R7 - postscale field bits 6 to 3 gives ratio of field plus one
// R8 - count and period read/write; reset gives count 00h, period FFh
// R9 - control bit 2 runs the timer when one, stops it when zero
// R10 - count or control write clears prescaler and postscaler, not count
// R11 - any reset clears prescaler and postscaler counters
// R12 - flag stays until software clears; request needs flag and enable
// R13 - control bit 7 ignores writes, reads zero; control resets to zero
//
module pmt_timer
	import pmt_pkg::*;
#(
	parameter int COUNT_W = 8
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// avalon-mm slave
	input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [AVS_DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [AVS_DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// interrupt
	output logic IRQ
);

	generate
		if (COUNT_W < 1 || COUNT_W > 8)
		begin : g_bad_width
			$error("pmt_timer: COUNT_W must lie in 1..8");
		end
		// read data is packed as 24 zero bits over the low byte lane
		if (AVS_DATA_W != 32)
		begin : g_bad_data
			$error("pmt_timer: bus data must be 32 bits");
		end
		// the word offsets need five address bits
		if (AVS_ADDR_W < 5)
		begin : g_bad_addr
			$error("pmt_timer: bus address must be at least 5 bits");
		end
		// the postscaler counter and its select field are both 4 bits
		if (CTRL_POST_MSB - CTRL_POST_LSB != 3)
		begin : g_bad_post
			$error("pmt_timer: postscale field must be 4 bits");
		end
	endgenerate

	// bus handshake
	logic wait_reg;
	logic wait_next;
	logic [AVS_DATA_W-1:0] rdata_reg;
	logic bus_req;
	logic bus_take;
	logic bus_commit;
	logic wr_lane0;
	logic rd_commit;
	logic [7:0] wdata;
	logic [7:0] rd_mux;

	// address decode
	logic sel_count;
	logic sel_period;
	logic sel_ctrl;
	logic sel_irq_req;
	logic sel_irq_en;
	logic sel_state;

	// register writes
	logic wr_count;
	logic wr_period;
	logic wr_ctrl;
	logic wr_irq_en;

	// timer state
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] period_reg;
	logic timer_run_reg;
	logic [1:0] prescale_sel_reg;
	logic [3:0] postscale_sel_reg;
	logic [3:0] post_cnt_reg;
	logic count_match;
	logic match_event;
	logic post_fire;
	logic scaler_clear;
	logic [COUNT_W-1:0] count_next;
	logic [COUNT_W-1:0] period_next;
	logic [3:0] post_cnt_next;

	// interrupt state
	logic period_irq_flag_reg;
	logic period_irq_enable_reg;
	logic flag_clear;
	logic irq_reg;
	logic flag_next;
	logic irq_enable_next;

	pmt_tick_if tick_if ();

	pmt_prescaler u_prescaler (
		.clk(CLK),
		.srst(SRST),
		.tick(tick_if.div)
	);

	// request is held by the master: first edge answers, second commits
	assign bus_req = AVS_READ || AVS_WRITE;
	assign bus_take = bus_req && wait_reg;
	assign bus_commit = bus_req && !wait_reg;
	assign wr_lane0 = bus_commit && AVS_WRITE && AVS_BYTEENABLE[0];
	assign rd_commit = bus_commit && AVS_READ;
	assign wdata = AVS_WRITEDATA[7:0];

	// one-hot word select; misaligned or unknown offsets select nothing
	always_comb
	begin
		sel_count = 1'b0;
		sel_period = 1'b0;
		sel_ctrl = 1'b0;
		sel_irq_req = 1'b0;
		sel_irq_en = 1'b0;
		sel_state = 1'b0;
		case (AVS_ADDRESS)
			OFF_COUNT: sel_count = 1'b1;
			OFF_PERIOD: sel_period = 1'b1;
			OFF_CTRL: sel_ctrl = 1'b1;
			OFF_IRQ_REQ: sel_irq_req = 1'b1;
			OFF_IRQ_EN: sel_irq_en = 1'b1;
			OFF_STATE: sel_state = 1'b1;
			default: ;
		endcase
	end

	assign wr_count = wr_lane0 && sel_count;
	assign wr_period = wr_lane0 && sel_period;
	assign wr_ctrl = wr_lane0 && sel_ctrl;
	assign wr_irq_en = wr_lane0 && sel_irq_en;

	// waitrequest drops for exactly one cycle per held request
	always_comb
	begin
		wait_next = 1'b1;
		if (bus_take)
			wait_next = 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			wait_reg <= 1'b1;
		else
			wait_reg <= wait_next;
	end

	// read data; unused and unmapped bits read as zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (sel_count)
			rd_mux[COUNT_W-1:0] = count_reg; // see R8
		else if (sel_period)
			rd_mux[COUNT_W-1:0] = period_reg; // see R8
		else if (sel_ctrl)
		begin
			rd_mux[CTRL_POST_MSB:CTRL_POST_LSB] = postscale_sel_reg;
			rd_mux[CTRL_RUN_BIT] = timer_run_reg;
			rd_mux[CTRL_PRE_MSB:CTRL_PRE_LSB] = prescale_sel_reg;
			rd_mux[CTRL_UNUSED_BIT] = 1'b0; // see R13
		end
		else if (sel_irq_req)
			rd_mux[IRQ_FLAG_BIT] = period_irq_flag_reg;
		else if (sel_irq_en)
			rd_mux[IRQ_FLAG_BIT] = period_irq_enable_reg;
		else if (sel_state)
		begin
			rd_mux[STATE_POST_MSB:STATE_POST_LSB] = post_cnt_reg;
			rd_mux[STATE_MATCH_BIT] = count_match;
			rd_mux[STATE_RUN_BIT] = timer_run_reg;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			rdata_reg <= RDATA_RST;
		else if (bus_take && AVS_READ)
			rdata_reg <= {24'h00_0000, rd_mux};
	end

	// control register run bit; bit 7 is not stored
	always_ff @(posedge CLK)
	begin
		if (SRST)
			timer_run_reg <= CTRL_RST[CTRL_RUN_BIT]; // see R13
		else if (wr_ctrl)
			timer_run_reg <= wdata[CTRL_RUN_BIT]; // see R9
	end

	// prescale select field
	always_ff @(posedge CLK)
	begin
		if (SRST)
			prescale_sel_reg <= CTRL_RST[CTRL_PRE_MSB:CTRL_PRE_LSB];
		else if (wr_ctrl)
			prescale_sel_reg <= wdata[CTRL_PRE_MSB:CTRL_PRE_LSB]; // see R2
	end

	// postscale select field
	always_ff @(posedge CLK)
	begin
		if (SRST)
			postscale_sel_reg <= CTRL_RST[CTRL_POST_MSB:CTRL_POST_LSB];
		else if (wr_ctrl)
			postscale_sel_reg <= wdata[CTRL_POST_MSB:CTRL_POST_LSB]; // see R7
	end

	// prescaler steering
	assign scaler_clear = wr_count || wr_ctrl; // see R10
	assign tick_if.run = timer_run_reg; // see R9
	assign tick_if.clear = scaler_clear; // see R10
	assign tick_if.prescale_sel = prescale_sel_reg; // see R1 R2

	// period register
	always_comb
	begin
		period_next = period_reg;
		if (wr_period)
			period_next = wdata[COUNT_W-1:0]; // see R8
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			period_reg <= PERIOD_RST[COUNT_W-1:0]; // see R8
		else
			period_reg <= period_next;
	end

	// counter; a control write leaves the count alone
	assign count_match = (count_reg == period_reg); // see R4
	assign match_event = tick_if.pre_tick && count_match; // see R5

	// a count write wins over a tick that falls in the same cycle
	always_comb
	begin
		count_next = count_reg;
		if (wr_count)
			count_next = wdata[COUNT_W-1:0]; // see R8
		else if (tick_if.pre_tick && count_match)
			count_next = '0; // see R5
		else if (tick_if.pre_tick)
			count_next = count_reg + COUNT_W'(1); // see R3 R4
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			count_reg <= COUNT_RST[COUNT_W-1:0]; // see R8
		else
			count_reg <= count_next;
	end

	// postscaler: fires once every postscale_sel + 1 matches
	assign post_fire = match_event && (post_cnt_reg == postscale_sel_reg);

	always_comb
	begin
		post_cnt_next = post_cnt_reg;
		if (scaler_clear)
			post_cnt_next = 4'h0; // see R10
		else if (post_fire)
			post_cnt_next = 4'h0; // see R7
		else if (match_event)
			post_cnt_next = post_cnt_reg + 4'h1; // see R5 R7
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			post_cnt_reg <= 4'h0; // see R11
		else
			post_cnt_reg <= post_cnt_next;
	end

	// sticky flag, cleared by the read that saw it set
	assign flag_clear = rd_commit && sel_irq_req &&
		rdata_reg[IRQ_FLAG_BIT];

	// set wins over the read-clear in the same cycle
	always_comb
	begin
		flag_next = period_irq_flag_reg;
		if (post_fire)
			flag_next = 1'b1; // see R6
		else if (flag_clear)
			flag_next = 1'b0; // see R12
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			period_irq_flag_reg <= 1'b0;
		else
			period_irq_flag_reg <= flag_next;
	end

	always_comb
	begin
		irq_enable_next = period_irq_enable_reg;
		if (wr_irq_en)
			irq_enable_next = wdata[IRQ_FLAG_BIT]; // see R12
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			period_irq_enable_reg <= 1'b0;
		else
			period_irq_enable_reg <= irq_enable_next;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			irq_reg <= 1'b0;
		else
			irq_reg <= period_irq_flag_reg && period_irq_enable_reg; // see R12
	end

	// outputs
	assign AVS_READDATA = rdata_reg;
	assign AVS_WAITREQUEST = wait_reg;
	assign IRQ = irq_reg;

endmodule : pmt_timer

/* File: test/pmt_timer_checker.sv */
`timescale 1ns/1ps
module pmt_timer_checker
	import pmt_pkg::*;
#(
	parameter int COUNT_W = 8
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// avalon-mm slave
	input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [AVS_DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [AVS_DATA_W-1:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// interrupt
	input wire logic IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	logic rd_done;
	assign rd_done = AVS_READ && !AVS_WAITREQUEST;
	a_wait_one: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("waitrequest held too long");
	a_wait_pulse: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_rdata_hold: assert property (
		!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
		else $error("read data moved without a read");
	a_rdata_upper: assert property (
		rd_done |-> AVS_READDATA[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_ctrl_top: assert property (
		rd_done && AVS_ADDRESS == OFF_CTRL |-> !AVS_READDATA[CTRL_UNUSED_BIT])
		else $error("control bit 7 reads one");
	a_unmapped_zero: assert property (
		rd_done && AVS_ADDRESS > OFF_STATE |-> AVS_READDATA == RDATA_RST)
		else $error("unmapped read not zero");
	a_irq_mask: assert property (
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_IRQ_EN
		&& AVS_BYTEENABLE[0] && !AVS_WRITEDATA[IRQ_FLAG_BIT] |-> ##2 !IRQ)
		else $error("irq stays up after mask");
	a_irq_clear: assert property (
		$fell(IRQ) |-> $past(!AVS_WAITREQUEST, 2))
		else $error("irq dropped without an access");
	a_reset_quiet: assert property (
		$fell(SRST) |-> !IRQ && AVS_WAITREQUEST)
		else $error("outputs not quiet after reset");
	cover property ($rose(IRQ));
	cover property (rd_done && AVS_ADDRESS == OFF_IRQ_REQ && IRQ);
	cover property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_CTRL);
endmodule : pmt_timer_checker

/* File: test/pmt_timer_tb_top.sv */
`timescale 1ns/1ps
module pmt_timer_tb_top;
	import pmt_pkg::*;
	logic clk = 0;
	logic srst = 1;
	logic [4:0] adr = '0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wd = '0;
	logic [3:0] be = 4'h1;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [31:0] keep;
	logic wreq;
	logic irq;
	int num_errors = 0;
	int n_compared = 0;
	int n;
	pmt_timer uut (.CLK(clk), .SRST(srst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .IRQ(irq));
	always #2.5 clk = ~clk;
	task automatic report_and_stop();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string s, input logic [31:0] g,
		input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// one bus cycle; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wreq !== 1'b0 && ++t < 50);
		q = rdat;
		if (t >= 50)
			num_errors++;
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask : bus
	task automatic rdc(input string s, input logic [4:0] a,
		input logic [31:0] e);
		bus(0, a, 32'h0000_0000);
		chk(s, q, e);
	endtask : rdc
	// run from a cleared count until the interrupt, then clear the flag
	task automatic run(input logic [7:0] c, input int e);
		bus(1, OFF_COUNT, 32'h0000_0000);
		bus(1, OFF_CTRL, {24'h00_0000, c});
		n = 0;
		do @(posedge clk); while (irq !== 1'b1 && ++n < 2000);
		bus(1, OFF_CTRL, 32'h0000_0000);
		chk("irq delay", 32'(n > e - 9 && n < e + 9), 32'h1);
		rdc("flag set", OFF_IRQ_REQ, 32'h0000_0002);
		rdc("flag cleared", OFF_IRQ_REQ, 32'h0000_0000);
	endtask : run
	initial
	begin
		#100us;
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		rdc("count", OFF_COUNT, 32'h0000_0000);
		rdc("period", OFF_PERIOD, 32'h0000_00FF);
		rdc("ctrl", OFF_CTRL, 32'h0000_0000);
		bus(1, OFF_CTRL, 32'h0000_0080);
		rdc("ctrl", OFF_CTRL, 32'h0000_0000);
		bus(1, OFF_COUNT, 32'h0000_0033);
		bus(1, OFF_CTRL, 32'h0000_0078);
		rdc("count", OFF_COUNT, 32'h0000_0033);
		rdc("ctrl", OFF_CTRL, 32'h0000_0078);
		be <= 4'h0;
		bus(1, OFF_PERIOD, 32'h0000_0005);
		be <= 4'h1;
		rdc("period", OFF_PERIOD, 32'h0000_00FF);
		bus(1, OFF_PERIOD, 32'h0000_0003);
		rdc("period", OFF_PERIOD, 32'h0000_0003);
		rdc("unmapped", 5'h18, 32'h0000_0000);
		bus(1, OFF_IRQ_EN, 32'h0000_0002);
		for (int i = 0; i < 4; i++)
			run(8'h0C | i[7:0], 32 * (i == 0 ? 1 : i == 1 ? 4 : 16));
		run(8'h04, 16);
		run(8'h7C, 256);
		bus(1, OFF_IRQ_EN, 32'h0000_0000);
		bus(1, OFF_CTRL, 32'h0000_0004);
		repeat (40) @(posedge clk);
		chk("masked irq", {31'h0, irq}, 32'h0);
		bus(1, OFF_CTRL, 32'h0000_0000);
		rdc("masked flag", OFF_IRQ_REQ, 32'h0000_0002);
		bus(0, OFF_COUNT, 32'h0000_0000);
		keep = q;
		repeat (40) @(posedge clk);
		rdc("stopped count", OFF_COUNT, keep);
		bus(1, OFF_CTRL, 32'h0000_007C);
		repeat (30) @(posedge clk);
		srst <= 1;
		repeat (5) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		rdc("count", OFF_COUNT, 32'h0000_0000);
		rdc("period", OFF_PERIOD, 32'h0000_00FF);
		rdc("ctrl", OFF_CTRL, 32'h0000_0000);
		rdc("flag", OFF_IRQ_REQ, 32'h0000_0000);
		rdc("post count", OFF_STATE, 32'h0000_0000);
		report_and_stop();
	end
endmodule : pmt_timer_tb_top
bind pmt_timer pmt_timer_checker #(.COUNT_W(COUNT_W)) u_chk (.CLK(CLK),
	.SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
